// ### verification/peci_cpu_model.sv
// behavioural peci master and cpu side feeding the bank
`timescale 1ns/1ps
module peci_cpu_model (
  input wire logic clk_i,
  output logic cpu_detected_o,
  output logic temp_valid_o,
  output peci_fan_pkg::reg8_t temp_o,
  output logic bad_code_o
);
  initial begin
    cpu_detected_o = 1'b0;
    temp_valid_o = 1'b0;
    temp_o = 8'h00;
    bad_code_o = 1'b0;
  end
  task automatic send_temp(input peci_fan_pkg::reg8_t t);
    @(posedge clk_i);
    temp_valid_o <= 1'b1;
    temp_o <= t;
    @(posedge clk_i);
    temp_valid_o <= 1'b0;
    temp_o <= ~t; // reading is not held once the strobe drops
  endtask
  task automatic flag(input bit bad);
    @(posedge clk_i);
    bad_code_o <= bad;
    cpu_detected_o <= !bad;
    @(posedge clk_i);
    bad_code_o <= 1'b0;
    cpu_detected_o <= 1'b0;
  endtask
endmodule // peci_cpu_model

// ### verification/peci_fan_properties.sv
// port-level checker for the peci fan control register bank
`timescale 1ns/1ps
module peci_fan_properties
  import peci_fan_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5c
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire reg8_t reg_addr_i,
  input wire reg8_t reg_wdata_i,
  input wire reg8_t reg_rdata_o,
  input wire logic bad_completion_i,
  input wire logic peci_monitor_en_i,
  input wire logic poll_req_o,
  input wire logic retry_mark_o,
  input wire logic cpu_write_permit_o,
  input wire logic failsafe_active_o,
  input wire reg8_t pwm1_duty_o,
  input wire reg8_t pwm2_duty_o,
  input wire reg8_t pwm3_duty_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ======
  // register port
  rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  ident_read_a: assert property (reg_rd_i && reg_addr_i == 8'h3e
    |=> reg_rdata_o == MAKER_CODE)
    else $error("maker code read wrong");
  link_rsvd_a: assert property (reg_rd_i && reg_addr_i == 8'h37
    |=> (reg_rdata_o & 8'h4c) == 8'h00)
    else $error("link config reserved bits set");
  span_rsvd_a: assert property (reg_rd_i && reg_addr_i == 8'h3c
    |=> reg_rdata_o[3:0] == 4'h0)
    else $error("ramp span reserved bits set");
  write_permit_a: assert property (reg_wr_i && reg_addr_i == 8'h37
    |=> cpu_write_permit_o == |($past(reg_wdata_i) & 8'h80))
    else $error("write permit does not follow bit 7");
  // ======
  // peci side
  retry_fall_a: assert property ($fell(retry_mark_o) |-> $past(bad_completion_i))
    else $error("retry marking dropped without a bad completion");
  failsafe_full_a: assert property (failsafe_active_o
    |-> pwm1_duty_o == 8'hff && pwm2_duty_o == 8'hff && pwm3_duty_o == 8'hff)
    else $error("fail-safe without full duty");
  monitor_off_a: assert property (!peci_monitor_en_i [*4]
    |-> !failsafe_active_o && !poll_req_o && pwm1_duty_o == 8'h00)
    else $error("activity while monitor disabled");
  poll_pulse_a: assert property (poll_req_o |=> !poll_req_o)
    else $error("poll request longer than one cycle");
  cover property ($rose(failsafe_active_o));
  cover property ($fell(retry_mark_o));
  cover property (poll_req_o);
endmodule // peci_fan_properties

// ### verification/testbench.sv
// self-checking bench of the peci fan control register bank
`timescale 1ns/1ps
module testbench;
  import peci_fan_pkg::*;
  localparam reg8_t MAKER = 8'h3c; // arbitrary
  logic clk_i, resetn_i, reg_wr_i, reg_rd_i, en, ofs64, prb, rd_d, prb_d;
  logic poll, retry, wpermit, fs, det, tv, bad;
  logic [2:0] asg, psel;
  logic [15:0] r;
  reg8_t reg_addr_i, reg_wdata_i, reg_rdata_o, mind, tmp, meas, seen, half;
  reg8_t p[3];
  reg8_t c[3];
  reg8_t rst_v[8];
  reg8_t exp_q[$];
  int errors, cmp_count, cycles;
  int div[4] = '{1, 2, 5, 10};

  peci_fan_control_config #(.SEC_CYCLES(100), .MAKER_CODE(MAKER)) DUT (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .cpu_detected_i(det), .peci_temp_valid_i(tv), .peci_temp_i(tmp),
    .bad_completion_i(bad), .peci_monitor_en_i(en), .temp_offset64_i(ofs64),
    .pwm_peci_assign_i(asg), .minimum_duty_i(mind), .poll_req_o(poll),
    .retry_mark_o(retry), .cpu_write_permit_o(wpermit), .failsafe_active_o(fs),
    .pwm1_duty_o(p[0]), .pwm2_duty_o(p[1]), .pwm3_duty_o(p[2]));
  peci_cpu_model cpu (.clk_i(clk_i), .cpu_detected_o(det), .temp_valid_o(tv),
    .temp_o(tmp), .bad_code_o(bad));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // ======
  // shared tasks
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input reg8_t got, input reg8_t want);
    cmp_count++;
    if (got !== want) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic end_sim;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input reg8_t a, input reg8_t d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input reg8_t a, input reg8_t e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    exp_q.push_back(e);
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic look(input logic [2:0] s, input reg8_t e);
    @(posedge clk_i);
    prb <= 1'b1;
    psel <= s;
    exp_q.push_back(e);
    @(posedge clk_i);
    prb <= 1'b0;
  endtask
  task automatic measure;
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end while (!poll && n < 300);
    n = 0;
    do begin @(posedge clk_i); n++; end while (!poll && n < 300);
    meas = 8'(n);
  endtask
  // ======
  // result watcher
  always_comb begin
    case (psel)
      3'd0, 3'd1, 3'd2: seen = p[psel];
      3'd3: seen = {7'h00, fs};
      3'd4: seen = {7'h00, retry};
      3'd5: seen = {7'h00, wpermit};
      default: seen = meas;
    endcase
  end
  always @(posedge clk_i) begin
    rd_d <= reg_rd_i;
    prb_d <= prb;
    if (rd_d) chk(reg_rdata_o, exp_q.pop_front());
    if (prb_d) chk(seen, exp_q.pop_front());
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end
  // ======
  // scenarios
  initial begin
    resetn_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    prb = 1'b0;
    psel = 3'd0;
    meas = 8'h00;
    // random fan setup; the monitor may start off, the register port must not care
    r = lfsr(16'ha193);
    mind = r[7:0];
    asg = r[10:8] | 3'b001;
    ofs64 = r[11];
    en = r[12];
    // one degree over the start on the 2-degree span is half way up the ramp
    half = mind + (8'hff - mind) / 8'd2;
    rst_v = '{8'h32, 8'hff, 8'hff, 8'hff, 8'hd6, 8'hc0, 8'h00, MAKER};
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (rst_v[i]) rd(8'(8'h37 + i), rst_v[i]);
    rd(8'h40, 8'h00);
    look(3'd4, 8'h01);
    wr(8'h37, 8'hff);
    rd(8'h37, 8'hb3);
    look(3'd5, 8'h01);
    wr(8'h3c, 8'hff);
    rd(8'h3c, 8'hf0);
    wr(8'h3e, 8'h00);
    rd(8'h3e, MAKER);
    wr(8'h37, 8'h02);
    look(3'd5, 8'h00);
    cpu.flag(1'b0);
    rd(8'h37, 8'h03);
    cpu.flag(1'b1);
    look(3'd4, 8'h00);
    wr(8'h37, 8'h01);
    look(3'd4, 8'h01);
    en <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(8'h37, 8'(k << 4));
      measure();
      look(3'd6, 8'(100 / div[k]));
    end
    wr(8'h3d, 8'h80);
    wr(8'h3b, 8'h20);
    wr(8'h3c, 8'h00);
    for (int i = 0; i < 3; i++) begin
      r = lfsr(r);
      c[i] = r[7:0];
      wr(8'(8'h38 + i), c[i]);
      rd(8'(8'h38 + i), c[i]);
    end
    cpu.send_temp(8'h21);
    for (int i = 0; i < 3; i++) begin
      look(3'(i), asg[i] ? (c[i] < half ? c[i] : half) : 8'h00);
    end
    cpu.send_temp(8'h48);
    for (int i = 0; i < 3; i++) begin
      look(3'(i), asg[i] ? c[i] : 8'h00);
    end
    cpu.send_temp(8'h20);
    for (int i = 0; i < 3; i++) begin
      look(3'(i), 8'h00);
    end
    wr(8'h3d, 8'h50);
    cpu.send_temp(8'h51);
    look(3'd3, 8'h01);
    look(3'd2, 8'hff);
    cpu.send_temp(8'h4c);
    look(3'd3, 8'h01);
    cpu.send_temp(8'h4b);
    look(3'd3, 8'h00);
    wr(8'h3d, 8'h80);
    cpu.send_temp(8'h7f);
    look(3'd3, 8'h00);
    wr(8'h3d, 8'h10);
    ofs64 <= 1'b0;
    cpu.send_temp(8'h90);
    look(3'd3, 8'h00);
    ofs64 <= 1'b1;
    cpu.send_temp(8'h90);
    look(3'd3, 8'h01);
    en <= 1'b0;
    repeat (4) @(posedge clk_i);
    look(3'd3, 8'h00);
    look(3'd0, 8'h00);
    // the watcher takes the last note one edge after the probe drops
    repeat (3) @(posedge clk_i);
    end_sim();
  end
endmodule // testbench

bind peci_fan_control_config peci_fan_properties #(.MAKER_CODE(MAKER_CODE)) props (
  .clk_i, .resetn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
  .bad_completion_i, .peci_monitor_en_i, .poll_req_o, .retry_mark_o,
  .cpu_write_permit_o, .failsafe_active_o, .pwm1_duty_o, .pwm2_duty_o, .pwm3_duty_o);

// ### verilog/fan_ramp_calc.sv
// automatic duty from peci temperature, start point and ramp span
`timescale 1ns/1ps
`include "peci_fan_params.svh"
module fan_ramp_calc (
  input wire peci_fan_pkg::temp_t temp_i,
  input wire peci_fan_pkg::temp_t start_i,
  input wire logic [3:0] span_code_i,
  input wire peci_fan_pkg::reg8_t minimum_duty_i,
  input wire peci_fan_pkg::reg8_t ceiling_i,
  output peci_fan_pkg::reg8_t duty_o
);
  import peci_fan_pkg::*;

  // span in sixths of a degree, so 2.5 and the thirds stay exact
  function automatic logic [8:0] span_sixths(input logic [3:0] code);
    case (code)
      4'h0: span_sixths = 9'd12;
      4'h1: span_sixths = 9'd15;
      4'h2: span_sixths = 9'd20;
      4'h3: span_sixths = 9'd24;
      4'h4: span_sixths = 9'd30;
      4'h5: span_sixths = 9'd40;
      4'h6: span_sixths = 9'd48;
      4'h7: span_sixths = 9'd60;
      4'h8: span_sixths = 9'd80;
      4'h9: span_sixths = 9'd96;
      4'ha: span_sixths = 9'd120;
      4'hb: span_sixths = 9'd160;
      4'hc: span_sixths = 9'd192;
      4'hd: span_sixths = 9'd240;
      4'he: span_sixths = 9'd320;
      default: span_sixths = 9'd480;
    endcase
  endfunction

  logic [9:0] excess;
  logic [8:0] headroom;
  logic [21:0] ramp;
  logic [9:0] raw;
  reg8_t auto_duty;

  always_comb begin
    excess = 10'(temp_i - start_i);
    headroom = 9'(`DUTY_FULL) - {1'b0, minimum_duty_i};
    ramp = (22'(excess) * 22'd6 * 22'(headroom)) / 22'(span_sixths(span_code_i)); // RULE_08
    raw = (ramp > 22'(headroom)) ? 10'(`DUTY_FULL) : 10'({1'b0, minimum_duty_i}) + 10'(ramp);
    if (temp_i > start_i) begin // RULE_06
      auto_duty = raw[7:0];
    end else begin
      auto_duty = `DUTY_ZERO;
    end
    // ceilings share the linear 0x00..0xff scale
    duty_o = (auto_duty > ceiling_i) ? ceiling_i : auto_duty; // RULE_05 RULE_13
  end
endmodule // fan_ramp_calc

// ### verilog/peci_fan_control_config.sv
// peci configuration, limit and fan-link register bank with fail-safe and duty output
`timescale 1ns/1ps
`include "peci_fan_params.svh"
module peci_fan_control_config #(
  parameter int unsigned SEC_CYCLES = `POLL_BASE_NS / `CLK_PERIOD_NS,
  parameter logic [7:0] MAKER_CODE = 8'h5c // arbitrary value
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire peci_fan_pkg::reg8_t reg_addr_i,
  input wire peci_fan_pkg::reg8_t reg_wdata_i,
  output peci_fan_pkg::reg8_t reg_rdata_o,
  // peci master side, same clock
  input wire logic cpu_detected_i,
  input wire logic peci_temp_valid_i,
  input wire peci_fan_pkg::reg8_t peci_temp_i,
  input wire logic bad_completion_i,
  // configuration held elsewhere
  input wire logic peci_monitor_en_i,
  input wire logic temp_offset64_i,
  input wire logic [2:0] pwm_peci_assign_i,
  input wire peci_fan_pkg::reg8_t minimum_duty_i,
  // outputs
  output logic poll_req_o,
  output logic retry_mark_o,
  output logic cpu_write_permit_o,
  output logic failsafe_active_o,
  output peci_fan_pkg::reg8_t pwm1_duty_o,
  output peci_fan_pkg::reg8_t pwm2_duty_o,
  output peci_fan_pkg::reg8_t pwm3_duty_o
);
  import peci_fan_pkg::*;

  // ==============================================================
  // helpers
  function automatic temp_t to_celsius(input reg8_t v, input logic off64);
    if (off64) begin
      to_celsius = $signed({1'b0, v}) - `OFFSET64_BIAS; // RULE_14
    end else begin
      to_celsius = $signed({v[7], v});
    end
  endfunction

  // ==============================================================
  // register state
  reg8_t link_cfg_reg, link_cfg_next;
  reg8_t ceiling_reg [3];
  reg8_t ceiling_next [3];
  reg8_t start_temp_reg, start_temp_next;
  reg8_t span_reg, span_next;
  reg8_t limit_reg, limit_next;
  reg8_t rdata_reg, rdata_next;
  reg8_t temp_reg, temp_next;
  logic retry_ok_reg, retry_ok_next;

  always_comb begin
    link_cfg_next = link_cfg_reg;
    start_temp_next = start_temp_reg;
    span_next = span_reg;
    limit_next = limit_reg;
    for (int i = 0; i < 3; i++) begin
      ceiling_next[i] = ceiling_reg[i];
    end
    if (reg_wr_i) begin
      if (reg_addr_i == `OFS_LINK_CONFIG) begin
        link_cfg_next = reg_wdata_i & `MASK_LINK_CONFIG; // RULE_16
      end else if (reg_addr_i == `OFS_PWM1_CEILING) begin
        ceiling_next[0] = reg_wdata_i; // RULE_05
      end else if (reg_addr_i == `OFS_PWM2_CEILING) begin
        ceiling_next[1] = reg_wdata_i; // RULE_05
      end else if (reg_addr_i == `OFS_PWM3_CEILING) begin
        ceiling_next[2] = reg_wdata_i; // RULE_05
      end else if (reg_addr_i == `OFS_FAN_START_TEMP) begin
        start_temp_next = reg_wdata_i;
      end else if (reg_addr_i == `OFS_FAN_RAMP_SPAN) begin
        span_next = reg_wdata_i & `MASK_FAN_RAMP_SPAN; // RULE_16
      end else if (reg_addr_i == `OFS_FAILSAFE_LIMIT) begin
        limit_next = reg_wdata_i;
      end
    end
    // detection beats a same-cycle software clear
    if (cpu_detected_i) begin
      link_cfg_next[`BIT_PROC_PRESENT] = 1'b1; // RULE_01
    end
  end

  // ==============================================================
  // read port, unmapped offsets read zero
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd_i) begin
      if (reg_addr_i == `OFS_LINK_CONFIG) begin
        rdata_next = link_cfg_reg;
      end else if (reg_addr_i == `OFS_PWM1_CEILING) begin
        rdata_next = ceiling_reg[0];
      end else if (reg_addr_i == `OFS_PWM2_CEILING) begin
        rdata_next = ceiling_reg[1];
      end else if (reg_addr_i == `OFS_PWM3_CEILING) begin
        rdata_next = ceiling_reg[2];
      end else if (reg_addr_i == `OFS_FAN_START_TEMP) begin
        rdata_next = start_temp_reg;
      end else if (reg_addr_i == `OFS_FAN_RAMP_SPAN) begin
        rdata_next = span_reg;
      end else if (reg_addr_i == `OFS_FAILSAFE_LIMIT) begin
        rdata_next = limit_reg;
      end else if (reg_addr_i == `OFS_MAKER_IDENTITY) begin
        rdata_next = MAKER_CODE; // RULE_12
      end else begin
        rdata_next = `DUTY_ZERO;
      end
    end
  end

  // ==============================================================
  // poll rate divider
  logic [31:0] poll_cnt_reg, poll_cnt_next;
  logic [31:0] poll_period;
  logic poll_reg, poll_next;
  poll_rate_t rate;

  always_comb begin
    rate = poll_rate_t'(link_cfg_reg[`BIT_RATE_HI:`BIT_RATE_LO]);
    case (rate) // RULE_03
      rate_1_per_s: poll_period = 32'(SEC_CYCLES) / `POLL_DIV_1;
      rate_2_per_s: poll_period = 32'(SEC_CYCLES) / `POLL_DIV_2;
      rate_5_per_s: poll_period = 32'(SEC_CYCLES) / `POLL_DIV_5;
      default: poll_period = 32'(SEC_CYCLES) / `POLL_DIV_10;
    endcase
    poll_next = 1'b0;
    poll_cnt_next = poll_cnt_reg + 32'd1;
    if (!peci_monitor_en_i) begin
      poll_cnt_next = 32'd0; // RULE_15
    end else if (poll_cnt_reg + 32'd1 >= poll_period) begin
      poll_cnt_next = 32'd0;
      poll_next = 1'b1;
    end
  end

  // ==============================================================
  // retry marking: after a bad completion code, suppress when asked
  // held as a permit so the retry pin comes straight from its flop
  always_comb begin
    retry_ok_next = retry_ok_reg;
    if (bad_completion_i) begin
      retry_ok_next = !link_cfg_reg[`BIT_RETRY_SUPPRESS]; // RULE_02
    end else if (!link_cfg_reg[`BIT_RETRY_SUPPRESS]) begin
      retry_ok_next = 1'b1; // RULE_02
    end
  end

  // ==============================================================
  // temperature capture and fail-safe with hysteresis
  temp_t temp_c, start_c, limit_c;
  logic fs_reg, fs_next;

  always_comb begin
    temp_next = temp_reg;
    if (peci_temp_valid_i && peci_monitor_en_i) begin
      temp_next = peci_temp_i; // RULE_15
    end
    temp_c = to_celsius(temp_reg, temp_offset64_i); // RULE_14
    start_c = to_celsius(start_temp_reg, temp_offset64_i);
    limit_c = to_celsius(limit_reg, temp_offset64_i);
    fs_next = fs_reg;
    if (limit_reg == `FAILSAFE_OFF_CODE || !peci_monitor_en_i) begin
      fs_next = 1'b0; // RULE_10
    end else if (temp_c > limit_c) begin
      fs_next = 1'b1; // RULE_09
    end else if (temp_c < limit_c - `FAILSAFE_HYST_C) begin
      fs_next = 1'b0; // RULE_11
    end
  end

  // ==============================================================
  // per-output duty
  reg8_t auto_duty [3];
  reg8_t duty_reg [3];
  reg8_t duty_next [3];

  generate
    for (genvar g = 0; g < 3; g++) begin : g_pwm
      fan_ramp_calc u_ramp (
        .temp_i(temp_c),
        .start_i(start_c),
        .span_code_i(span_reg[`BIT_SPAN_HI:`BIT_SPAN_LO]),
        .minimum_duty_i(minimum_duty_i),
        .ceiling_i(ceiling_reg[g]),
        .duty_o(auto_duty[g])
      );
      always_comb begin
        // fail-safe flag and forced duty move on the same edge
        if (fs_next) begin
          duty_next[g] = `DUTY_FULL; // RULE_09
        end else if (pwm_peci_assign_i[g] && peci_monitor_en_i) begin
          duty_next[g] = auto_duty[g]; // RULE_06
        end else begin
          duty_next[g] = `DUTY_ZERO;
        end
      end
    end
  endgenerate

  // ==============================================================
  // registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link_cfg_reg <= `RST_LINK_CONFIG;
      start_temp_reg <= `RST_FAN_START_TEMP;
      span_reg <= `RST_FAN_RAMP_SPAN;
      limit_reg <= `RST_FAILSAFE_LIMIT;
      rdata_reg <= `DUTY_ZERO;
      temp_reg <= `DUTY_ZERO;
      retry_ok_reg <= 1'b1;
      poll_cnt_reg <= 32'd0;
      poll_reg <= 1'b0;
      fs_reg <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        ceiling_reg[i] <= `RST_PWM_CEILING;
        duty_reg[i] <= `DUTY_ZERO;
      end
    end else begin
      link_cfg_reg <= link_cfg_next;
      start_temp_reg <= start_temp_next;
      span_reg <= span_next;
      limit_reg <= limit_next;
      rdata_reg <= rdata_next;
      temp_reg <= temp_next;
      retry_ok_reg <= retry_ok_next;
      poll_cnt_reg <= poll_cnt_next;
      poll_reg <= poll_next;
      fs_reg <= fs_next;
      for (int i = 0; i < 3; i++) begin
        ceiling_reg[i] <= ceiling_next[i];
        duty_reg[i] <= duty_next[i];
      end
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign poll_req_o = poll_reg;
  assign retry_mark_o = retry_ok_reg;
  assign cpu_write_permit_o = link_cfg_reg[`BIT_WRITE_PERMIT]; // RULE_04
  assign failsafe_active_o = fs_reg;
  assign pwm1_duty_o = duty_reg[0];
  assign pwm2_duty_o = duty_reg[1];
  assign pwm3_duty_o = duty_reg[2];
endmodule // peci_fan_control_config

// ### verilog/peci_fan_params.svh
// offsets, field positions, reset values and timing counts of the peci fan control bank
// What this block does
// RULE_01 - bit 0 of link config reads 1 once a peci processor is detected
// RULE_02 - retry-suppress bit 1 set stops retry marking after bad completion codes
// RULE_03 - bits 5:4 pick polling: 1, 2, 5 or 10 polls per second
// RULE_04 - bit 7 set allows peci write commands; clear blocks them all
// RULE_05 - three writable per-output duty ceilings, reset 0xff, cap each duty
// RULE_06 - above start temperature, peci fans run minimum duty then ramp up
// RULE_07 - software keeps start temperature at or below 175 C in absolute mode
// RULE_08 - bits 7:4 choose ramp span from 2 to 80 degrees, default 32
// RULE_09 - peci reading above fail-safe limit forces every pwm to full duty
// RULE_10 - fail-safe limit value 0x80 disables the forced full duty
// RULE_11 - forced full duty holds until temperature drops below limit minus hysteresis
// RULE_12 - read-only eight-bit maker identification register, always readable
// RULE_13 - duty scale is linear, 0x00 is zero and 0xff full duty
// RULE_14 - temperatures and limits read as two's complement or offset-64
// RULE_15 - peci monitoring runs only while the monitor enable bit is set
// RULE_16 - reserved bits of link config and ramp span read zero, ignore writes
`ifndef PECI_FAN_PARAMS_SVH
`define PECI_FAN_PARAMS_SVH

// ==============================================================
// register offsets
`define OFS_LINK_CONFIG 8'h37
`define OFS_PWM1_CEILING 8'h38
`define OFS_PWM2_CEILING 8'h39
`define OFS_PWM3_CEILING 8'h3a
`define OFS_FAN_START_TEMP 8'h3b
`define OFS_FAN_RAMP_SPAN 8'h3c
`define OFS_FAILSAFE_LIMIT 8'h3d
`define OFS_MAKER_IDENTITY 8'h3e

// ==============================================================
// reset values and writable masks
`define RST_LINK_CONFIG 8'h32
`define RST_PWM_CEILING 8'hff
`define RST_FAN_START_TEMP 8'hd6
`define RST_FAN_RAMP_SPAN 8'hc0
`define RST_FAILSAFE_LIMIT 8'h00
`define MASK_LINK_CONFIG 8'hb3
`define MASK_FAN_RAMP_SPAN 8'hf0
`define FAILSAFE_OFF_CODE 8'h80
`define DUTY_FULL 8'hff
`define DUTY_ZERO 8'h00

// ==============================================================
// field positions
`define BIT_PROC_PRESENT 0
`define BIT_RETRY_SUPPRESS 1
`define BIT_RATE_LO 4
`define BIT_RATE_HI 5
`define BIT_WRITE_PERMIT 7
`define BIT_SPAN_LO 4
`define BIT_SPAN_HI 7

// ==============================================================
// temperature and timing
`define OFFSET64_BIAS 9'sd64
`define FAILSAFE_HYST_C 9'sd4
`define POLL_BASE_NS 1000000000
`define CLK_PERIOD_NS 25
`define POLL_DIV_1 32'd1
`define POLL_DIV_2 32'd2
`define POLL_DIV_5 32'd5
`define POLL_DIV_10 32'd10

`endif

// ### verilog/peci_fan_pkg.sv
// types shared by the peci fan control bank
package peci_fan_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic signed [8:0] temp_t;
  typedef enum logic [1:0] {
    rate_1_per_s = 2'h0,
    rate_2_per_s = 2'h1,
    rate_5_per_s = 2'h2,
    rate_10_per_s = 2'h3
  } poll_rate_t;
endpackage
